/* File: rtl/tpwm_pkg.sv */
// Package with register map, field positions, reset values and codes of the triggered PWM timer.
package tpwm_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] TPWM_OFF_CTRL_A = 4'h0;
    localparam logic [3:0] TPWM_OFF_CTRL_B = 4'h1;
    localparam logic [3:0] TPWM_OFF_OUTC = 4'h2;
    localparam logic [3:0] TPWM_OFF_CNT = 4'h3;
    localparam logic [3:0] TPWM_OFF_PER = 4'h4;
    localparam logic [3:0] TPWM_OFF_DUTY = 4'h5;
    localparam logic [3:0] TPWM_OFF_EDGE = 4'h6;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TPWM_CA_RUN = 7;
    localparam int TPWM_CA_CKS_LO = 0;
    localparam int TPWM_CB_SOFT = 6;
    localparam int TPWM_CB_EVT = 5;
    localparam int TPWM_CB_MD_LO = 0;
    localparam int TPWM_OC_OE0 = 0;
    localparam int TPWM_OC_IDL0 = 1;
    localparam int TPWM_OC_OE1 = 2;
    localparam int TPWM_OC_ACT1 = 3;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] TPWM_RST_8 = 8'h00;
    localparam logic [15:0] TPWM_RST_16 = 16'h0000;
    localparam logic [15:0] TPWM_CNT_IDLE = 16'hffff;
    localparam logic [15:0] TPWM_CNT_ZERO = 16'h0000;
    localparam logic [2:0] TPWM_MODE_TRIG = 3'h2;
    localparam logic [1:0] TPWM_EDGE_RISE = 2'h1;
    localparam logic [1:0] TPWM_EDGE_FALL = 2'h2;
    localparam logic [1:0] TPWM_EDGE_BOTH = 2'h3;
    typedef enum logic [0:0] {TPWM_WAIT = 1'b0, TPWM_COUNT = 1'b1} tpwm_state_t;
endpackage : tpwm_pkg

/* File: rtl/tpwm_tick_if.sv */
// Interface carrying the count-clock prescaler select and tick.
`timescale 1ns/1ps
interface tpwm_tick_if;
    logic [2:0] sel;
    logic run;
    logic tick;
    modport ctrl (output sel, output run, input tick);
    modport gen (input sel, input run, output tick);
endinterface : tpwm_tick_if

/* File: rtl/tpwm_prescaler.sv */
// Prescaler that turns the system clock into count-clock ticks.
`timescale 1ns/1ps
module tpwm_prescaler
(
    input wire logic clk, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    tpwm_tick_if.gen tk // Select, run and tick.
);
    import tpwm_pkg::*;
    logic [7:0] div_r;

    // Free-running divider; select n ticks once every 2**n clocks.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            div_r <= TPWM_RST_8;
        else if (!tk.run)
            div_r <= TPWM_RST_8;
        else
            div_r <= div_r + 8'h01;
    end

    // A tick fires when all low divider bits below the selected position are set.
    always_comb
    begin
        logic [7:0] mask;
        mask = 8'h00;
        mask = (8'h01 << tk.sel) - 8'h01;
        tk.tick = tk.run && ((div_r & mask) == mask);
    end
endmodule : tpwm_prescaler

/* File: rtl/tpwm_top.sv */
// Triggered PWM timer: registers, trigger detect, counter, compares and outputs.
`timescale 1ns/1ps
module tpwm_top
(
    input wire logic clk, // System clock, 100 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic [3:0] addr, // Register index.
    input wire logic [15:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [15:0] rdata, // Read data, valid the cycle after rd.
    input wire logic trig_in, // External trigger pin.
    output logic timer_out0, // Square wave output pin.
    output logic timer_out1, // PWM output pin.
    output logic period_match_irq, // One-cycle period match pulse.
    output logic duty_match_irq // One-cycle duty match pulse.
);
    import tpwm_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] outc_r;
    logic [1:0] edge_r;
    logic [15:0] per_r;
    logic [15:0] duty_r;
    logic [15:0] per_buf_r;
    logic [15:0] duty_buf_r;
    logic [15:0] cnt_r;
    logic armed_r;
    logic soft_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_s3_r;
    logic pwm_r;
    logic sq_r;
    tpwm_state_t state_r;

    logic run_en;
    logic mode_ok;
    logic tick;
    logic hw_edge;
    logic trig;
    logic per_hit;
    logic duty_hit;
    logic wr_duty;
    logic pwm_nxt;
    logic sq_nxt;

    tpwm_tick_if tk ();

    assign run_en = ctrl_a_r[TPWM_CA_RUN];
    assign mode_ok = ctrl_b_r[TPWM_CB_MD_LO +: 3] == TPWM_MODE_TRIG;
    assign tk.sel = ctrl_a_r[TPWM_CA_CKS_LO +: 3];
    assign tk.run = run_en && mode_ok;
    assign tick = tk.tick;
    assign wr_duty = wr && (addr == TPWM_OFF_DUTY);

    // Count clock source; the event-clock input is not part of this mode.
    tpwm_prescaler u_presc
    (
        .clk(clk),
        .nrst(nrst),
        .tk(tk)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Plain control registers; soft_trigger is write-only and never stored.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_a_r <= TPWM_RST_8;
            ctrl_b_r <= TPWM_RST_8;
            outc_r <= TPWM_RST_8;
            edge_r <= TPWM_EDGE_RISE;
            per_r <= TPWM_RST_16;
            duty_r <= TPWM_RST_16;
        end
        else if (wr)
        begin
            unique case (addr)
                TPWM_OFF_CTRL_A: ctrl_a_r <= wdata[7:0];
                TPWM_OFF_CTRL_B: ctrl_b_r <= {1'b0, wdata[6:0]} & ~(8'h01 << TPWM_CB_SOFT);
                TPWM_OFF_OUTC: outc_r <= wdata[7:0];
                TPWM_OFF_EDGE: edge_r <= wdata[1:0];
                TPWM_OFF_PER: per_r <= wdata;
                TPWM_OFF_DUTY: duty_r <= wdata;
                default: ;
            endcase
        end
    end

    // Software trigger pulse, one clock after the write.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            soft_r <= 1'b0;
        else
            soft_r <= wr && (addr == TPWM_OFF_CTRL_B) && wdata[TPWM_CB_SOFT];
    end

    // Read mux; unmapped indices answer zero.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= TPWM_RST_16;
        else if (rd)
        begin
            unique case (addr)
                TPWM_OFF_CTRL_A: rdata <= {8'h00, ctrl_a_r};
                TPWM_OFF_CTRL_B: rdata <= {8'h00, ctrl_b_r};
                TPWM_OFF_OUTC: rdata <= {8'h00, outc_r};
                TPWM_OFF_EDGE: rdata <= {14'h0000, edge_r};
                TPWM_OFF_CNT: rdata <= cnt_r;
                TPWM_OFF_PER: rdata <= per_r;
                TPWM_OFF_DUTY: rdata <= duty_r;
                default: rdata <= TPWM_RST_16;
            endcase
        end
        else
            rdata <= TPWM_RST_16;
    end

    // ------------------------------------------------------------
    // Trigger detection
    // ------------------------------------------------------------
    // Two flip-flops synchronise the pin; the third only feeds edge detection.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end
        else
        begin
            trig_s1_r <= trig_in;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    always_comb
    begin
        unique case (edge_r)
            TPWM_EDGE_RISE: hw_edge = trig_s2_r && !trig_s3_r;
            TPWM_EDGE_FALL: hw_edge = !trig_s2_r && trig_s3_r;
            TPWM_EDGE_BOTH: hw_edge = trig_s2_r ^ trig_s3_r;
            default: hw_edge = 1'b0;
        endcase
    end

    // Triggers act at once, not on a count tick, so a restart is never delayed.
    assign trig = tk.run && (hw_edge || soft_r);
    // Match terms: period ends on the tick after the counter sits at the buffer.
    assign per_hit = tick && (state_r == TPWM_COUNT) && (cnt_r == per_buf_r);
    // Duty match looks at the value the counter takes next, so out1 falls as it arrives.
    assign duty_hit = tick && (state_r == TPWM_COUNT) && (per_hit ?
        (duty_buf_r == TPWM_CNT_ZERO) : ((cnt_r + 16'h0001) == duty_buf_r));

    // ------------------------------------------------------------
    // Counter and state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= TPWM_WAIT;
            cnt_r <= TPWM_CNT_IDLE;
        end
        else if (!tk.run)
        begin
            state_r <= TPWM_WAIT;
            cnt_r <= TPWM_CNT_IDLE;
        end
        else if (trig)
        begin
            state_r <= TPWM_COUNT;
            cnt_r <= TPWM_CNT_ZERO;
        end
        else if (per_hit)
            cnt_r <= TPWM_CNT_ZERO;
        else if (tick && state_r == TPWM_COUNT)
            cnt_r <= cnt_r + 16'h0001;
    end

    // Buffer copy armed by a duty write, done at the period clear, a trigger restart or while waiting; set beats clear.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            armed_r <= 1'b0;
        else if (wr_duty)
            armed_r <= 1'b1;
        else if ((per_hit || trig || state_r == TPWM_WAIT) && armed_r)
            armed_r <= 1'b0;
    end

    // Once a duty write arms them, buffers reload at a period clear, trigger restart, or while waiting.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            per_buf_r <= TPWM_RST_16;
            duty_buf_r <= TPWM_RST_16;
        end
        else if ((per_hit || trig || state_r == TPWM_WAIT) && (armed_r || wr_duty))
        begin
            per_buf_r <= per_r;
            duty_buf_r <= wr_duty ? wdata : duty_r;
        end
    end

    // ------------------------------------------------------------
    // Waveforms and interrupts
    // ------------------------------------------------------------
    // Out1 level: active from clear until duty match; a restart forces it active.
    // A zero duty keeps a restart inactive, so a 0% setting survives triggers.
    always_comb
    begin
        pwm_nxt = pwm_r;
        if (!tk.run)
            pwm_nxt = 1'b0;
        else if (trig)
            pwm_nxt = (duty_buf_r != TPWM_CNT_ZERO);
        else if (duty_hit)
            pwm_nxt = 1'b0;
        else if (per_hit)
            pwm_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pwm_r <= 1'b0;
        else
            pwm_r <= pwm_nxt;
    end

    // Square wave toggles per period end and per trigger restart.
    always_comb
    begin
        sq_nxt = sq_r;
        if (!tk.run)
            sq_nxt = 1'b0;
        else if (per_hit || (trig && state_r == TPWM_COUNT))
            sq_nxt = !sq_r;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sq_r <= 1'b0;
        else
            sq_r <= sq_nxt;
    end

    // A trigger in the same cycle suppresses both match pulses.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            period_match_irq <= 1'b0;
            duty_match_irq <= 1'b0;
        end
        else
        begin
            period_match_irq <= per_hit && !trig;
            duty_match_irq <= duty_hit && !trig;
        end
    end

    // Pin drivers: enables gate outputs, idle level for out0, polarity for out1.
    // Pins take the next levels, so a pin edge lands with its match pulse.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            timer_out0 <= 1'b0;
            timer_out1 <= 1'b0;
        end
        else
        begin
            timer_out0 <= outc_r[TPWM_OC_OE0] ? sq_nxt : outc_r[TPWM_OC_IDL0];
            timer_out1 <= outc_r[TPWM_OC_OE1] ?
                (pwm_nxt ^ outc_r[TPWM_OC_ACT1]) : outc_r[TPWM_OC_ACT1];
        end
    end
endmodule : tpwm_top

/* File: tb/tpwm_trig_src.sv */
// External trigger source model that drives the timer's trigger pin.
`timescale 1ns/1ps
module tpwm_trig_src
(
    input wire logic clk, // System clock.
    input wire logic go, // One-cycle request for a trigger pulse.
    output logic trig // Trigger pin, low when idle.
);
    // ------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------
    logic [2:0] cnt_r = 3'h0;
    // A four-clock pulse outlasts the two-flop synchroniser, so no edge is lost.
    always_ff @(posedge clk)
    begin
        if (go)
            cnt_r <= 3'h4;
        else if (cnt_r != 3'h0)
            cnt_r <= cnt_r - 3'h1;
    end
    assign trig = (cnt_r != 3'h0); // Rising edge is the valid trigger edge.
endmodule : tpwm_trig_src

/* File: tb/tpwm_top_assertions.sv */
// Checker of the triggered PWM timer ports.
`timescale 1ns/1ps
module tpwm_top_assertions
(
    input wire logic clk, // System clock.
    input wire logic nrst, // Reset, active low.
    input wire logic [3:0] addr, // Register index.
    input wire logic rd, // Read strobe.
    input wire logic [15:0] rdata, // Read data.
    input wire logic timer_out0, // Square wave pin.
    input wire logic timer_out1, // PWM pin.
    input wire logic period_match_irq, // Period pulse.
    input wire logic duty_match_irq // Duty pulse.
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Reset must hold every output low, so this one is not disabled by reset.
    AST_RST_OUT: assert property (disable iff (1'b0) !nrst |-> !(timer_out0 | timer_out1 |
        period_match_irq | duty_match_irq) && rdata == 16'h0000)
        else $error("Output not low during reset.");
    AST_RD_IDLE: assert property (!rd |=> rdata == 16'h0000)
        else $error("Read data seen without a read.");
    AST_RD_UNMAP: assert property (rd && addr > 4'h6 |=> rdata == 16'h0000)
        else $error("Unmapped read not zero.");
    AST_RD_BYTE: assert property (rd && addr < 4'h3 |=> rdata[15:8] == 8'h00)
        else $error("Byte register high half not zero.");
    AST_SOFT_RD0: assert property (rd && addr == 4'h1 |=> !rdata[6])
        else $error("Soft trigger bit reads back set.");
    AST_OUTC_RD: assert property (rd && addr == 4'h2 |=> rdata[15:4] == 12'h000)
        else $error("Output control spare bits set.");
    AST_PIRQ_PULSE: assert property ($rose(period_match_irq) |=> !period_match_irq)
        else $error("Period pulse longer than one cycle.");
    AST_DIRQ_PULSE: assert property (duty_match_irq |=> !duty_match_irq)
        else $error("Duty pulse longer than one cycle.");
    C_PIRQ: cover property (period_match_irq);
    C_DIRQ: cover property (duty_match_irq);
    C_CNT_RD: cover property (rd && addr == 4'h3);
endmodule : tpwm_top_assertions
bind tpwm_top tpwm_top_assertions chk_u (.clk(clk), .nrst(nrst), .addr(addr), .rd(rd),
    .rdata(rdata), .timer_out0(timer_out0), .timer_out1(timer_out1),
    .period_match_irq(period_match_irq), .duty_match_irq(duty_match_irq));

/* File: tb/tpwm_top_test.sv */
// Self-checking testbench of the triggered PWM timer.
`timescale 1ns/1ps
module tpwm_top_test;
    import tpwm_pkg::*;
    typedef struct {logic w; logic [3:0] a; logic [15:0] d; logic [15:0] e;} tpwm_row_t;
    // ------------------------------------------------------------
    // Signals, clock, model and design
    // ------------------------------------------------------------
    logic clk = 1'b0, nrst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0, trig_in, o0;
    logic timer_out0, timer_out1, period_match_irq, duty_match_irq;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, a, b;
    int n_errors = 0, compares = 0, n, k;
    tpwm_row_t rows [13];
    // Free-running 100 MHz clock.
    always #5 clk = ~clk;
    tpwm_trig_src src_u (.clk(clk), .go(go), .trig(trig_in));
    tpwm_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trig_in(trig_in), .timer_out0(timer_out0), .timer_out1(timer_out1),
        .period_match_irq(period_match_irq), .duty_match_irq(duty_match_irq));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr_reg(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= ad; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] ad, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1; addr <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // Waits for 0 period pulse, 1 duty pulse, 2 out1 high, 3 out1 low; a hang ends the run.
    task wait_ev(input int s, output int cnt);
        for (cnt = 1; cnt < 300; cnt++)
        begin
            @(posedge clk);
            #1;
            if ((s == 0 && period_match_irq === 1'b1) || (s == 1 && duty_match_irq === 1'b1) ||
                (s == 2 && timer_out1 === 1'b1) || (s == 3 && timer_out1 === 1'b0))
                return;
        end
        n_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        summarize();
    endtask : wait_ev
    task set_pwm(input logic [15:0] per, input logic [15:0] duty);
        wr_reg(TPWM_OFF_PER, per);
        wr_reg(TPWM_OFF_DUTY, duty);
        wait_ev(0, n);
        wait_ev(0, n);
    endtask : set_pwm
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rows = '{'{0, 0, 0, 16'h0000}, '{0, 1, 0, 16'h0000}, '{0, 2, 0, 16'h0000},
            '{0, 4, 0, 16'h0000}, '{0, 5, 0, 16'h0000}, '{0, 6, 0, 16'h0001},
            '{1, 0, 16'h0005, 16'h0005}, '{1, 1, 16'h0062, 16'h0022}, '{1, 2, 16'h000f, 16'h000f},
            '{1, 4, 16'h1234, 16'h1234}, '{1, 5, 16'habcd, 16'habcd}, '{1, 6, 16'h0002, 16'h0002},
            '{1, 15, 16'hffff, 16'h0000}};
        // A real falling edge resets the design before the first clock edge.
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (k = 0; k < 13; k++)
        begin
            if (rows[k].w)
                wr_reg(rows[k].a, rows[k].d);
            rd_reg(rows[k].a, a);
            check(a, rows[k].e);
        end
        $display("register table done");
        wr_reg(TPWM_OFF_EDGE, 16'h0001);
        wr_reg(TPWM_OFF_OUTC, 16'h0005);
        wr_reg(TPWM_OFF_PER, 16'h0007);
        wr_reg(TPWM_OFF_DUTY, 16'h0003);
        wr_reg(TPWM_OFF_CTRL_B, 16'h0002);
        wr_reg(TPWM_OFF_CTRL_A, 16'h0080);
        rd_reg(TPWM_OFF_CNT, a);
        check(a, TPWM_CNT_IDLE);
        wr_reg(TPWM_OFF_CTRL_B, 16'h0042);
        wait_ev(0, n);
        wait_ev(0, n);
        check(16'(n), 16'h0008);
        o0 = timer_out0;
        wait_ev(0, n);
        check(timer_out0, !o0);
        wait_ev(1, n);
        check(timer_out1, 1'b0);
        wait_ev(2, n);
        wait_ev(3, n);
        check(16'(n), 16'h0003);
        rd_reg(TPWM_OFF_CNT, a);
        rd_reg(TPWM_OFF_CNT, b);
        check(b, (a + 16'h0002) & 16'h0007);
        $display("soft trigger pwm done");
        wr_reg(TPWM_OFF_PER, 16'h0005);
        wait_ev(0, n);
        wait_ev(0, n);
        wait_ev(0, n);
        check(16'(n), 16'h0008);
        wr_reg(TPWM_OFF_DUTY, 16'h0003);
        wait_ev(0, n);
        wait_ev(0, n);
        check(16'(n), 16'h0006);
        set_pwm(16'd40, 16'd3);
        wait_ev(1, n);
        o0 = timer_out0;
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        wait_ev(2, n);
        check(16'(n < 8), 16'h0001);
        check(timer_out0, !o0);
        $display("external trigger done");
        wr_reg(TPWM_OFF_OUTC, 16'h000e);
        wait_ev(0, n);
        wait_ev(2, n);
        wait_ev(3, n);
        check(16'(n), 16'd38);
        check(timer_out0, 1'b1);
        wr_reg(TPWM_OFF_OUTC, 16'h0000);
        wait_ev(0, n);
        check({timer_out0, timer_out1}, 2'b00);
        wr_reg(TPWM_OFF_OUTC, 16'h0005);
        for (k = 0; k < 2; k++)
        begin
            set_pwm(16'd40, k ? 16'd0 : 16'd41);
            n = 0;
            repeat (41) @(negedge clk) n += (timer_out1 !== (k ? 1'b0 : 1'b1));
            check(16'(n), 16'h0000);
        end
        wait_ev(1, n);
        check(duty_match_irq, 1'b1);
        wr_reg(TPWM_OFF_CTRL_A, 16'h0000);
        rd_reg(TPWM_OFF_CNT, a);
        rd_reg(TPWM_OFF_CNT, b);
        check(b, a);
        $display("stop and levels done");
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        check({timer_out0, timer_out1, period_match_irq, duty_match_irq}, 4'h0);
        @(posedge clk);
        nrst <= 1'b1;
        rd_reg(TPWM_OFF_CTRL_A, a);
        check(a, TPWM_RST_16);
        $display("second reset done");
        summarize();
    end
endmodule : tpwm_top_test
